// File: src/lprd_top.sv
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lprd_top (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Command submission
   input wire logic cmd_valid_i,
   input wire logic cmd_is_feature_i,
   input wire logic [127:0] cmd_buffer_pointer_i,
   input wire logic [31:0] cmd_dw10_i,
   input wire logic [31:0] cmd_dw11_i,
   input wire logic [31:0] cmd_dw12_i,
   input wire logic [31:0] cmd_dw13_i,
   output logic cmd_ready_o,
   // Data mover request
   output logic xfer_req_o,
   output logic [127:0] xfer_buffer_pointer_o,
   output logic [7:0] xfer_page_identifier_o,
   output logic [3:0] xfer_page_specific_field_o,
   output logic [63:0] xfer_offset_o,
   output logic [31:0] xfer_numd_o,
   input wire logic xfer_done_i,
   // Completion entry
   output logic cpl_valid_o,
   output logic [15:0] cpl_status_o,
   output logic [31:0] cpl_dw0_o,
   // Event clear
   output logic evt_clear_o,
   output logic [7:0] evt_page_identifier_o
);
   typedef struct packed {
      lprd_pkg::lprd_state_t state;
      logic [1:0] ctrl;
      logic [7:0] tbl_addr;
      logic [31:0] feat_dw0;
      logic [31:0] cmd_cnt;
      logic [31:0] rdata;
      logic [127:0] buffer_pointer;
      logic [7:0] page_identifier;
      logic [3:0] page_specific_field;
      logic retain_event_bit;
      logic [31:0] numd;
      logic [63:0] offset;
      logic misaligned;
      logic [15:0] last_status;
      logic cpl_valid;
      logic [15:0] cpl_status;
      logic [31:0] cpl_dw0;
      logic evt_clear;
      logic [7:0] evt_page;
   } lprd_top_t;

   lprd_top_t st_r;
   lprd_top_t st_nxt;

   lprd_mem_if tbl_if ();

   lprd_page_table u_table (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .port(tbl_if.mem)
   );

   // Transfer count from dwords ten and eleven
   function automatic logic [31:0] lprd_count(
      input logic ext_en,
      input logic [31:0] dw10,
      input logic [31:0] dw11
   );
      logic [31:0] cnt;
      cnt = '0;
      if (ext_en) begin
         cnt = {dw11[lprd_pkg::LPRD_CNT_HI_LSB +: 16], dw10[lprd_pkg::LPRD_CNT_LO_LSB +: 16]};
      end else begin
         cnt = {20'h0_0000, dw10[lprd_pkg::LPRD_CNT_LO_LSB +: lprd_pkg::LPRD_CNT_SHORT_W]};
      end
      return cnt;
   endfunction

   logic ext_en;
   logic align_chk;
   logic [63:0] raw_offset;
   logic [63:0] page_size;
   logic bad_page;
   logic bad_offset;

   assign ext_en = st_r.ctrl[lprd_pkg::LPRD_CTRL_EXT_BIT];
   assign align_chk = st_r.ctrl[lprd_pkg::LPRD_CTRL_ALIGN_BIT];
   assign raw_offset = {cmd_dw13_i, cmd_dw12_i};
   assign page_size = {32'h0000_0000, tbl_if.rdata};
   assign bad_page = (tbl_if.rdata == 32'h0000_0000);
   assign bad_offset = (st_r.offset > page_size);

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = 32'h0000_0000;
      st_nxt.cpl_valid = 1'b0;
      st_nxt.evt_clear = 1'b0;
      tbl_if.we = 1'b0;
      tbl_if.waddr = st_r.tbl_addr;
      tbl_if.wdata = reg_wdata_i;
      tbl_if.re = 1'b0;
      tbl_if.raddr = st_r.page_identifier;

      // Register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            lprd_pkg::LPRD_REG_CTRL: begin
               st_nxt.ctrl = reg_wdata_i[1:0];
            end
            lprd_pkg::LPRD_REG_TBL_ADDR: begin
               st_nxt.tbl_addr = reg_wdata_i[7:0];
            end
            lprd_pkg::LPRD_REG_TBL_DATA: begin
               tbl_if.we = 1'b1;
            end
            lprd_pkg::LPRD_REG_FEAT_DW0: begin
               st_nxt.feat_dw0 = reg_wdata_i;
            end
            default: begin
            end
         endcase
      end

      // Register reads; unmapped offsets return zero
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            lprd_pkg::LPRD_REG_CTRL: begin
               st_nxt.rdata = {30'h0000_0000, st_r.ctrl};
            end
            lprd_pkg::LPRD_REG_TBL_ADDR: begin
               st_nxt.rdata = {24'h00_0000, st_r.tbl_addr};
            end
            lprd_pkg::LPRD_REG_FEAT_DW0: begin
               st_nxt.rdata = st_r.feat_dw0;
            end
            lprd_pkg::LPRD_REG_STATUS: begin
               st_nxt.rdata = {st_r.last_status, 13'h0000, st_r.state};
            end
            lprd_pkg::LPRD_REG_CMD_CNT: begin
               st_nxt.rdata = st_r.cmd_cnt;
            end
            default: begin
            end
         endcase
      end

      unique case (st_r.state)
         lprd_pkg::LPRD_IDLE: begin
            if (cmd_valid_i) begin
               st_nxt.cmd_cnt = st_r.cmd_cnt + 32'h0000_0001;
               if (cmd_is_feature_i) begin
                  st_nxt.cpl_dw0 = st_r.feat_dw0;
                  st_nxt.cpl_status = lprd_pkg::LPRD_ST_SUCCESS;
                  st_nxt.state = lprd_pkg::LPRD_CPL;
               end else begin
                  // Only pointer and dwords ten to thirteen kept
                  st_nxt.buffer_pointer = cmd_buffer_pointer_i;
                  st_nxt.page_identifier = cmd_dw10_i[lprd_pkg::LPRD_PID_LSB +: 8];
                  st_nxt.page_specific_field = cmd_dw10_i[lprd_pkg::LPRD_PSF_LSB +: 4];
                  st_nxt.retain_event_bit = cmd_dw10_i[lprd_pkg::LPRD_RETAIN_BIT];
                  st_nxt.numd = lprd_count(ext_en, cmd_dw10_i, cmd_dw11_i);
                  st_nxt.misaligned = (raw_offset[1:0] != 2'b00);
                  st_nxt.offset = {raw_offset[63:2], 2'b00};
                  st_nxt.cpl_dw0 = 32'h0000_0000;
                  st_nxt.state = lprd_pkg::LPRD_LOOKUP;
               end
            end
         end
         lprd_pkg::LPRD_LOOKUP: begin
            tbl_if.re = 1'b1;
            st_nxt.state = lprd_pkg::LPRD_CHECK;
         end
         lprd_pkg::LPRD_CHECK: begin
            if (bad_page) begin
               st_nxt.cpl_status = lprd_pkg::LPRD_ST_INVALID_FIELD;
               st_nxt.state = lprd_pkg::LPRD_CPL;
            end else if (align_chk && st_r.misaligned) begin
               st_nxt.cpl_status = lprd_pkg::LPRD_ST_INVALID_FIELD;
               st_nxt.state = lprd_pkg::LPRD_CPL;
            end else if (bad_offset) begin
               st_nxt.cpl_status = lprd_pkg::LPRD_ST_INVALID_FIELD;
               st_nxt.state = lprd_pkg::LPRD_CPL;
            end else begin
               st_nxt.cpl_status = lprd_pkg::LPRD_ST_SUCCESS;
               st_nxt.state = lprd_pkg::LPRD_XFER;
            end
         end
         lprd_pkg::LPRD_XFER: begin
            // Full requested count goes to mover; tail is undefined
            if (xfer_done_i) begin
               st_nxt.evt_clear = ~st_r.retain_event_bit;
               st_nxt.evt_page = st_r.page_identifier;
               st_nxt.state = lprd_pkg::LPRD_CPL;
            end
         end
         lprd_pkg::LPRD_CPL: begin
            st_nxt.cpl_valid = 1'b1;
            st_nxt.last_status = st_r.cpl_status;
            st_nxt.state = lprd_pkg::LPRD_IDLE;
         end
         default: begin
            st_nxt.state = lprd_pkg::LPRD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
         st_r.state <= lprd_pkg::LPRD_IDLE;
         st_r.ctrl <= lprd_pkg::LPRD_CTRL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_o = st_r.rdata;
   assign cmd_ready_o = (st_r.state == lprd_pkg::LPRD_IDLE);
   assign xfer_req_o = (st_r.state == lprd_pkg::LPRD_XFER);
   assign xfer_buffer_pointer_o = st_r.buffer_pointer;
   assign xfer_page_identifier_o = st_r.page_identifier;
   assign xfer_page_specific_field_o = st_r.page_specific_field;
   assign xfer_offset_o = st_r.offset;
   assign xfer_numd_o = st_r.numd;
   assign cpl_valid_o = st_r.cpl_valid;
   assign cpl_status_o = st_r.last_status;
   assign cpl_dw0_o = st_r.cpl_dw0;
   assign evt_clear_o = st_r.evt_clear;
   assign evt_page_identifier_o = st_r.evt_page;
endmodule
`default_nettype wire

// File: pkg/lprd_pkg.sv
// Function
// - Feature-query completion posts one admin entry; dword 0 carries feature data.
// - Log-page command uses only buffer pointer and dwords ten to thirteen.
// - Unsupported page identifier aborts with Invalid Field in Command.
// - Without extended support, count comes from dword ten bits 27:16 only.
// - Count is high half over low half, taken as zero-based.
// - Oversized request still returns whole page; dwords past end undefined.
// - Retain bit zero clears the page's event after success; one keeps it.
// - Page-specific field reserved unless page uses it; bits 14:12 always reserved.
// - Page chosen by page identifier in dword ten bits 7:0.
// - 64-bit start offset: dword twelve low, dword thirteen high.
// - Misaligned offset rejected if checking enabled, otherwise low bits forced zero.
// - Offset beyond page size aborts with Invalid Field in Command.
// - Host buffer start taken from 128-bit buffer pointer.
package lprd_pkg;

   // Register offsets
   localparam logic [7:0] LPRD_REG_CTRL = 8'h00;
   localparam logic [7:0] LPRD_REG_TBL_ADDR = 8'h04;
   localparam logic [7:0] LPRD_REG_TBL_DATA = 8'h08;
   localparam logic [7:0] LPRD_REG_FEAT_DW0 = 8'h0c;
   localparam logic [7:0] LPRD_REG_STATUS = 8'h10;
   localparam logic [7:0] LPRD_REG_CMD_CNT = 8'h14;

   // Control bit positions
   localparam int LPRD_CTRL_EXT_BIT = 0;
   localparam int LPRD_CTRL_ALIGN_BIT = 1;
   localparam logic [1:0] LPRD_CTRL_RST = 2'h0;

   // Dword ten and dword eleven field positions
   localparam int LPRD_PID_LSB = 0;
   localparam int LPRD_PSF_LSB = 8;
   localparam int LPRD_RETAIN_BIT = 15;
   localparam int LPRD_CNT_LO_LSB = 16;
   localparam int LPRD_CNT_SHORT_W = 12;
   localparam int LPRD_CNT_HI_LSB = 0;

   // Completion status values
   localparam logic [15:0] LPRD_ST_SUCCESS = 16'h0000;
   localparam logic [15:0] LPRD_ST_INVALID_FIELD = 16'h0002;

   localparam int LPRD_TBL_DEPTH = 256;
   localparam logic [31:0] LPRD_TBL_RST = 32'h0000_0000;

   typedef enum logic [2:0] {
      LPRD_IDLE = 3'b000,
      LPRD_LOOKUP = 3'b001,
      LPRD_CHECK = 3'b010,
      LPRD_XFER = 3'b011,
      LPRD_CPL = 3'b100
   } lprd_state_t;

endpackage

// File: pkg/lprd_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lprd_mem_if;
   logic we;
   logic [7:0] waddr;
   logic [31:0] wdata;
   logic re;
   logic [7:0] raddr;
   logic [31:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output re, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input re, input raddr, output rdata);
endinterface
`default_nettype wire

// File: src/lprd_page_table.sv
`timescale 1ns/1ps
`default_nettype none
// Page size table in bytes; a zero entry marks an unsupported page
module lprd_page_table (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   lprd_mem_if.mem port
);
   typedef struct packed {
      logic [lprd_pkg::LPRD_TBL_DEPTH-1:0][31:0] mem;
      logic [31:0] rdata;
   } lprd_tbl_t;

   lprd_tbl_t st_r;
   lprd_tbl_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (port.we) begin
         st_nxt.mem[port.waddr] = port.wdata;
      end
      // Read sees the old word on a same-address write
      if (port.re) begin
         st_nxt.rdata = st_r.mem[port.raddr];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign port.rdata = st_r.rdata;
endmodule
`default_nettype wire

// File: sim/lprd_mover_model.sv
`timescale 1ns/1ps
`default_nettype none
// Data mover: answers each request once after delay_i plus one cycles of stall
module lprd_mover_model (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic req_i,
   input wire logic [3:0] delay_i,
   output logic done_o
);
   logic [3:0] cnt_r;
   logic sent_r;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !req_i) begin
         cnt_r <= 4'h0;
         sent_r <= 1'h0;
         done_o <= 1'h0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
         done_o <= (cnt_r == delay_i) && !sent_r;
         if (cnt_r == delay_i) sent_r <= 1'h1;
      end
   end
endmodule
`default_nettype wire

// File: sim/lprd_chk_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lprd_chk (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic cmd_valid_i,
   input wire logic cmd_is_feature_i,
   input wire logic cmd_ready_o,
   input wire logic xfer_req_o,
   input wire logic [63:0] xfer_offset_o,
   input wire logic xfer_done_i,
   input wire logic cpl_valid_o,
   input wire logic [15:0] cpl_status_o,
   input wire logic evt_clear_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   wire tk = cmd_valid_i && cmd_ready_o;
   a_ready_drop: assert property (tk |=> !cmd_ready_o)
      else $error("ready held after take");
   a_feat_cpl: assert property (tk && cmd_is_feature_i |-> ##2 cpl_valid_o)
      else $error("feature completion late");
   a_log_answer: assert property (tk && !cmd_is_feature_i |-> ##3 xfer_req_o or
      ##4 (cpl_valid_o && cpl_status_o == 16'h0002)) else $error("log answer wrong");
   a_done_cpl: assert property (xfer_req_o && xfer_done_i |-> ##2
      (cpl_valid_o && cpl_status_o == 16'h0000)) else $error("success completion wrong");
   a_offset_align: assert property (xfer_req_o |-> xfer_offset_o[1:0] == 2'h0)
      else $error("offset not aligned");
   a_cpl_pulse: assert property (cpl_valid_o |=> !cpl_valid_o)
      else $error("completion not a pulse");
   a_evt_cpl: assert property (evt_clear_o |=> cpl_valid_o && cpl_status_o == 16'h0000)
      else $error("event clear without success");
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
      else $error("read data outside slot");
   a_xfer_hold: assert property (xfer_req_o && !xfer_done_i |=> xfer_req_o)
      else $error("request dropped early");
   c_feat: cover property (tk && cmd_is_feature_i);
   c_xfer: cover property (xfer_req_o && xfer_done_i);
   c_evt: cover property (evt_clear_o);
endmodule
bind lprd_top lprd_chk u_chk (.clk_i, .sys_rst_i, .reg_rd_i, .reg_rdata_o, .cmd_valid_i,
   .cmd_is_feature_i, .cmd_ready_o, .xfer_req_o, .xfer_offset_o, .xfer_done_i,
   .cpl_valid_o, .cpl_status_o, .evt_clear_o);
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g,e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top;
   logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic cmd_valid_i = 0, cmd_is_feature_i = 0, cmd_ready_o, xfer_req_o, xfer_done_i;
   logic cpl_valid_o, evt_clear_o, ev, xf;
   logic [7:0] reg_addr_i = 0, xfer_page_identifier_o, evt_page_identifier_o;
   logic [31:0] reg_wdata_i = 0, reg_rdata_o, xfer_numd_o, cpl_dw0_o;
   logic [31:0] cmd_dw10_i = 0, cmd_dw11_i = 0, cmd_dw12_i = 0, cmd_dw13_i = 0;
   logic [127:0] cmd_buffer_pointer_i = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
   logic [127:0] xfer_buffer_pointer_o;
   logic [63:0] xfer_offset_o;
   logic [15:0] cpl_status_o;
   logic [3:0] xfer_page_specific_field_o, mv_dly = 0;
   int err_total = 0, n_compared = 0;
   lprd_top u_dut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .cmd_valid_i, .cmd_is_feature_i, .cmd_buffer_pointer_i, .cmd_dw10_i,
      .cmd_dw11_i, .cmd_dw12_i, .cmd_dw13_i, .cmd_ready_o, .xfer_req_o,
      .xfer_buffer_pointer_o, .xfer_page_identifier_o, .xfer_page_specific_field_o,
      .xfer_offset_o, .xfer_numd_o, .xfer_done_i, .cpl_valid_o, .cpl_status_o, .cpl_dw0_o,
      .evt_clear_o, .evt_page_identifier_o);
   lprd_mover_model u_mv (.clk_i, .sys_rst_i, .req_i(xfer_req_o), .delay_i(mv_dly),
      .done_o(xfer_done_i));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   task end_sim;
      if (err_total == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'h1;
      @(posedge clk_i);
      reg_wr_i <= 1'h0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'h1;
      @(posedge clk_i);
      reg_rd_i <= 1'h0;
      #1;
      `CHK(reg_rdata_o, e)
   endtask
   // Waits for the completion pulse, noting event clear and mover request
   task cmd(input logic f, input logic [31:0] a, b, c, d, input logic [15:0] st);
      @(posedge clk_i);
      cmd_is_feature_i <= f;
      cmd_dw10_i <= a;
      cmd_dw11_i <= b;
      cmd_dw12_i <= c;
      cmd_dw13_i <= d;
      cmd_valid_i <= 1'h1;
      @(posedge clk_i);
      cmd_valid_i <= 1'h0;
      ev = 0;
      xf = 0;
      for (int i = 0; i <= 40; i++) begin
         if (i == 40) begin
            err_total++;
            end_sim;
         end
         @(posedge clk_i);
         #1;
         ev |= evt_clear_o;
         xf |= xfer_req_o;
         if (cpl_valid_o === 1'h1) break;
      end
      `CHK(cpl_status_o, st)
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      @(posedge clk_i);
      #1;
      `CHK(cmd_ready_o, 1'h1)
      rd(8'h00, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      wr(8'h0c, 32'ha5a5_0001);
      rd(8'h0c, 32'ha5a5_0001);
      wr(8'h04, 32'h0000_0002);
      wr(8'h08, 32'h0000_0100);
      wr(8'h04, 32'h0000_0003);
      wr(8'h08, 32'h0000_0040);
      cmd(1'h1, 32'h0, 32'h0, 32'h0, 32'h0, 16'h0000);
      `CHK(cpl_dw0_o, 32'ha5a5_0001)
      cmd(1'h0, 32'h0000_0007, 32'h0, 32'h0, 32'h0, 16'h0002);
      `CHK(xf, 1'h0)
      `CHK(cpl_dw0_o, 32'h0000_0000)
      // Short count ignores upper nibble, reserved bits and dword eleven
      cmd(1'h0, 32'hf123_7a02, 32'h0000_0055, 32'h0000_0040, 32'h0, 16'h0000);
      `CHK(xfer_numd_o, 32'h0000_0123)
      `CHK(xfer_page_identifier_o, 8'h02)
      `CHK(xfer_page_specific_field_o, 4'ha)
      `CHK(xfer_offset_o, 64'h0000_0000_0000_0040)
      `CHK(xfer_buffer_pointer_o, cmd_buffer_pointer_i)
      `CHK(ev, 1'h1)
      `CHK(evt_page_identifier_o, 8'h02)
      wr(8'h00, 32'h0000_0001);
      mv_dly <= 4'h5;
      // Misaligned offset at page end, no check: low bits forced to zero
      cmd(1'h0, 32'hf123_8003, 32'hffff_0055, 32'h0000_0042, 32'h0, 16'h0000);
      `CHK(xfer_numd_o, 32'h0055_f123)
      `CHK(xfer_offset_o, 64'h0000_0000_0000_0040)
      `CHK(ev, 1'h0)
      wr(8'h00, 32'h0000_0003);
      cmd(1'h0, 32'h0000_0003, 32'h0, 32'h0000_0042, 32'h0, 16'h0002);
      cmd(1'h0, 32'h0000_0002, 32'h0, 32'h0000_0104, 32'h0, 16'h0002);
      cmd(1'h0, 32'h0000_0002, 32'h0, 32'h0, 32'h0000_0001, 16'h0002);
      `CHK(xf, 1'h0)
      rd(8'h10, 32'h0002_0000);
      rd(8'h14, 32'h0000_0007);
      end_sim;
   end
endmodule
`default_nettype wire
